/* hw/bliq_pkg.sv */
// Package: register map, field positions and reset values of the interrupt aggregator
`default_nettype none
package bliq_pkg;
   // Register byte addresses on the host I/O bus
   localparam logic [8:0] ADDR_ENABLE  = 9'h1e3;
   localparam logic [8:0] ADDR_PENDING = 9'h1e4;
   localparam int         ADDR_W       = 9;
   localparam int         REG_W        = 8;
   localparam int         SRC_N        = 5;
   // Bit positions of the five sources
   localparam int BIT_TIMER0     = 0;
   localparam int BIT_TIMER1     = 1;
   localparam int BIT_TIMER2     = 2;
   localparam int BIT_SYSTEM_ERR = 3;
   localparam int BIT_PARITY_ERR = 4;
   // Values after reset
   localparam logic [4:0] ENABLE_RST  = 5'h00;
   localparam logic [4:0] PENDING_RST = 5'h00;
   localparam logic [7:0] RD_ZERO     = 8'h00;
   // Bus slave states
   typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} bliq_bus_t;
endpackage : bliq_pkg
`default_nettype wire

/* hw/bliq_edge.sv */
// Synchronous rising-edge detector for the error lines and timer outputs
`default_nettype none
module bliq_edge
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Source levels, active high
   input  wire logic [4:0] level_i,
   // One-cycle pulse per rising edge
   output logic      [4:0] rise_o
);
   typedef struct packed
   {
      logic [4:0] prev_r;
      logic [4:0] rise_r;
   } bliq_edge_state_t;

   bliq_edge_state_t st_r;
   bliq_edge_state_t st_nxt;

   // Compare against the previous sample
   always_comb
   begin
      st_nxt        = st_r;
      st_nxt.prev_r = level_i;
      st_nxt.rise_r = level_i & ~st_r.prev_r;
   end

   // Reset holds prev high so a level already high at release is not an edge
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_r.prev_r <= 5'h1f;
         st_r.rise_r <= 5'h00;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign rise_o = st_r.rise_r;
endmodule : bliq_edge
`default_nettype wire

/* hw/bliq_regs.sv */
// Sticky pending flags with write-one-to-clear
`default_nettype none
module bliq_regs
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Event pulses and clear mask
   input  wire logic [4:0] set_i,
   input  wire logic [4:0] clr_i,
   // Pending flags
   output logic      [4:0] pending_o
);
   typedef struct packed
   {
      logic [4:0] pend_r;
   } bliq_regs_state_t;

   bliq_regs_state_t st_r;
   bliq_regs_state_t st_nxt;

   // Set wins over clear; flags stay until cleared
   always_comb
   begin
      st_nxt        = st_r;
      st_nxt.pend_r = (st_r.pend_r & ~clr_i) | set_i;
   end

   // Register the state
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_r.pend_r <= bliq_pkg::PENDING_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign pending_o = st_r.pend_r;
endmodule : bliq_regs
`default_nettype wire

/* hw/bliq_top.sv */
// Top: interrupt aggregator with classic Wishbone slave and combined interrupt output
`default_nettype none
// Contract
// - One combined interrupt output to host GPIO
// - Enable register; bit4 parity, bit3 system error
// - Enable bits 2..0 gate timers 2..0
// - Flag drives interrupt only while enabled
// - Pending register flags parity, system, timers
// - Writing one clears a pending flag
// - Flags set and readable regardless of enable
// - Timer flags set on rising output edge
// - Any assertion of error lines sets flag; one already asserted when reset is released sets none
// - Flag stays set until software clears
module bliq_top
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Wishbone slave
   input  wire logic       wb_cyc_i,
   input  wire logic       wb_stb_i,
   input  wire logic       wb_we_i,
   input  wire logic [8:0] wb_adr_i,
   input  wire logic [0:0] wb_sel_i,
   input  wire logic [7:0] wb_dat_i,
   output logic      [7:0] wb_dat_o,
   output logic            wb_ack_o,
   // Event sources
   input  wire logic       parity_err_n_i,
   input  wire logic       system_err_n_i,
   input  wire logic [2:0] timer_out_i,
   // Combined interrupt to host GPIO input
   output logic            irq_o
);
   typedef struct packed
   {
      bliq_pkg::bliq_bus_t bus_r;
      logic [4:0]          enable_r;
      logic [7:0]          dat_r;
      logic                ack_r;
      logic                irq_r;
   } bliq_top_state_t;

   bliq_top_state_t st_r;
   bliq_top_state_t st_nxt;
   logic [4:0]      level;
   logic [4:0]      rise;
   logic [4:0]      pending;
   logic [4:0]      clr;
   logic            req;
   logic            wr_ok;

   // Widen a five-bit field to the bus byte, reserved bits read zero
   function automatic logic [7:0] widen(input logic [4:0] f);
      widen = {3'b000, f};
   endfunction : widen

   // Error lines are active low; inverted so any assertion is a rising level
   always_comb
   begin
      level = 5'h00;
      level[bliq_pkg::BIT_PARITY_ERR] = ~parity_err_n_i;
      level[bliq_pkg::BIT_SYSTEM_ERR] = ~system_err_n_i;
      level[bliq_pkg::BIT_TIMER2:bliq_pkg::BIT_TIMER0] = timer_out_i;
   end

   // Edge detection keeps a long error pulse from re-setting a cleared flag
   bliq_edge u_edge
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .level_i (level),
      .rise_o  (rise)
   );

   // Request decode: only a fresh request in idle is served
   assign req   = wb_cyc_i & wb_stb_i & (st_r.bus_r == bliq_pkg::BUS_IDLE);
   assign wr_ok = req & wb_we_i & wb_sel_i[0];
   // Upper data bits ignored; software is expected to write them as zero
   assign clr   = (wr_ok && wb_adr_i == bliq_pkg::ADDR_PENDING) ? wb_dat_i[4:0] : 5'h00;

   // Pending flags set regardless of enable bits
   bliq_regs u_regs
   (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .set_i     (rise),
      .clr_i     (clr),
      .pending_o (pending)
   );

   // Bus slave, enable register and interrupt combine
   always_comb
   begin
      st_nxt       = st_r;
      st_nxt.ack_r = 1'b0;
      case (st_r.bus_r)
         bliq_pkg::BUS_IDLE:
         begin
            if (req)
            begin
               st_nxt.ack_r = 1'b1;
               st_nxt.bus_r = bliq_pkg::BUS_ACK;
               if (wr_ok && wb_adr_i == bliq_pkg::ADDR_ENABLE)
               begin
                  st_nxt.enable_r = wb_dat_i[4:0];
               end
               // Unmapped addresses read zero and still get ack
               case (wb_adr_i)
                  bliq_pkg::ADDR_ENABLE:  st_nxt.dat_r = widen(st_r.enable_r);
                  bliq_pkg::ADDR_PENDING: st_nxt.dat_r = widen(pending);
                  default:                st_nxt.dat_r = bliq_pkg::RD_ZERO;
               endcase
            end
         end
         bliq_pkg::BUS_ACK:
         begin
            // One idle cycle between accesses avoids a double ack
            st_nxt.bus_r = bliq_pkg::BUS_IDLE;
         end
         default:
         begin
            st_nxt.bus_r = bliq_pkg::BUS_IDLE;
         end
      endcase
      st_nxt.irq_r = |(pending & st_r.enable_r);
   end

   // Register the state
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_r.bus_r    <= bliq_pkg::BUS_IDLE;
         st_r.enable_r <= bliq_pkg::ENABLE_RST;
         st_r.dat_r    <= bliq_pkg::RD_ZERO;
         st_r.ack_r    <= 1'b0;
         st_r.irq_r    <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign wb_dat_o = st_r.dat_r;
   assign wb_ack_o = st_r.ack_r;
   assign irq_o    = st_r.irq_r;
endmodule : bliq_top
`default_nettype wire

/* sim/bliq_props.sv */
// Checker: bus handshake and interrupt relations at the aggregator ports
`default_nettype none
module bliq_props
(
   // Watched ports
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_we_i,
   input wire logic [8:0] wb_adr_i,
   input wire logic [0:0] wb_sel_i,
   input wire logic [7:0] wb_dat_i,
   input wire logic [7:0] wb_dat_o,
   input wire logic       wb_ack_o,
   input wire logic       parity_err_n_i,
   input wire logic       system_err_n_i,
   input wire logic [2:0] timer_out_i,
   input wire logic       irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic       wr;
   logic       rd;
   logic       en_w;
   logic [4:0] en_r;
   assign wr = wb_ack_o && wb_we_i;
   assign rd = wb_ack_o && !wb_we_i;
   assign en_w = wr && wb_sel_i[0] && wb_adr_i == bliq_pkg::ADDR_ENABLE;
   // Shadow of the enable byte, taken when the write is acknowledged
   always_ff @(posedge clk_i)
      en_r <= rst_i ? 5'h00 : (en_w ? wb_dat_i[4:0] : en_r);
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
   property p_ack; s_req |=> s_pulse; endproperty
   property p_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
   property p_rsv; rd |-> wb_dat_o[7:5] == 3'h0; endproperty
   property p_unm; rd && wb_adr_i != bliq_pkg::ADDR_ENABLE
      && wb_adr_i != bliq_pkg::ADDR_PENDING |-> wb_dat_o == 8'h00; endproperty
   property p_enrd; rd && wb_adr_i == bliq_pkg::ADDR_ENABLE |-> wb_dat_o[4:0] == en_r;
   endproperty
   property p_gate; irq_o |-> en_r != 5'h00; endproperty
   property p_mask0; en_w && wb_dat_i[4:0] == 5'h00 |=> ##1 !irq_o; endproperty
   // A flag holds the output up until software writes
   property p_fall; $fell(irq_o) |-> $past(wr) || $past(wr, 2) || $past(rst_i); endproperty
   a_ack: assert property (p_ack) else $error("ack timing");
   a_idle: assert property (p_idle) else $error("stray ack");
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   a_unm: assert property (p_unm) else $error("unmapped data");
   a_enrd: assert property (p_enrd) else $error("enable readback");
   a_gate: assert property (p_gate) else $error("irq without enable");
   a_mask0: assert property (p_mask0) else $error("irq after disable");
   a_fall: assert property (p_fall) else $error("irq dropped alone");
endmodule : bliq_props
bind bliq_top bliq_props u_props (.*);
`default_nettype wire

/* sim/bliq_host_model.sv */
// Host model: GPIO port sampling the combined interrupt on bit 6
`default_nettype none
module bliq_host_model
(
   // Clock, reset, pin and port image
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       irq_i,
   output logic      [7:0] port_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Unused port bits read zero
   always_ff @(posedge clk_i)
      port_o <= rst_i ? 8'h00 : {1'b0, irq_i, 6'h00};
endmodule : bliq_host_model
`default_nettype wire

/* sim/testbench.sv */
// Testbench: register, event and interrupt scenarios for the aggregator
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [8:0] EN = bliq_pkg::ADDR_ENABLE;
   localparam logic [8:0] PD = bliq_pkg::ADDR_PENDING;
   logic       clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
   logic [0:0] wb_sel_i;
   logic [8:0] wb_adr_i;
   logic [7:0] wb_dat_i, wb_dat_o, q, port;
   logic [4:0] lv;
   int         n_errors, num_checks;
   bliq_top uut (.*, .parity_err_n_i(~lv[4]), .system_err_n_i(~lv[3]), .timer_out_i(lv[2:0]));
   bliq_host_model host (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq_o), .port_o(port));
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e)
      begin
         n_errors++;
         $display("wrong value at %0t: %h expected %h", $time, s, e);
      end
   endtask : chk
   // One classic cycle; waits for ack, then idles a cycle
   task automatic wb(input logic w, input logic [8:0] a, input logic [7:0] d);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
      // No assumed latency; only the watchdog ends a hung wait
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      @(posedge clk_i);
   endtask : wb
   // Source levels, then long enough for flag and interrupt to land
   task automatic src(input logic [4:0] v);
      lv <= v;
      repeat (6) @(posedge clk_i);
   endtask : src
   task automatic t_regs;
      wb(0, PD, 0); chk(q, 8'h00);
      wb(0, 9'h1e5, 0); chk(q, 8'h00);
      wb(1, EN, 8'h15); wb(0, EN, 0); chk(q, 8'h15);
      wb_sel_i <= 1'b0; wb(1, EN, 8'h0a); wb_sel_i <= 1'b1;
      wb(0, EN, 0); chk(q, 8'h15);
      wb(1, EN, 8'h00);
   endtask : t_regs
   // Disabled sources still latch and poll
   task automatic t_poll;
      for (int i = 0; i < 5; i++)
      begin
         src(5'h01 << i); src(5'h00);
         wb(0, PD, 0); chk(q, 8'h01 << i);
         chk(irq_o, 0);
         wb(1, PD, 8'h01 << i); wb(0, PD, 0); chk(q, 8'h00);
      end
   endtask : t_poll
   task automatic t_irq;
      wb(1, EN, 8'h01); src(5'h01); chk(irq_o, 1);
      chk(port, 8'h40);
      wb(1, PD, 8'h01); repeat (3) @(posedge clk_i); chk(irq_o, 0);
      chk(port, 8'h00);
      wb(0, PD, 0); chk(q, 8'h00);
      src(5'h00); wb(1, EN, 8'h00);
   endtask : t_irq
   // A clear on the edge where the rise pulse sets the flag loses; the flag stays set
   task automatic t_collide;
      lv <= 5'h02; @(posedge clk_i);
      wb(1, PD, 8'h02); wb(0, PD, 0); chk(q, 8'h02);
      lv <= 5'h00; wb(1, PD, 8'h02); wb(0, PD, 0); chk(q, 8'h00);
   endtask : t_collide
   // Mid-run reset; a source held high at release is no edge
   task automatic t_reset;
      wb(1, EN, 8'h01); src(5'h01); chk(irq_o, 1);
      rst_i <= 1'b1; repeat (2) @(posedge clk_i);
      rst_i <= 1'b0; @(posedge clk_i);
      chk(irq_o, 0);
      wb(0, EN, 0); chk(q, 8'h00);
      wb(0, PD, 0); chk(q, 8'h00);
      src(5'h00);
   endtask : t_reset
   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   initial
   begin
      clk_i = 0;
      forever #12.5 clk_i = ~clk_i;
   end
   // Watchdog, far beyond the few hundred cycles needed
   initial
   begin
      #50000 n_errors++;
      report_and_stop();
   end
   initial
   begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i, lv} = 0;
      rst_i = 1;
      repeat (12) @(posedge clk_i);
      {rst_i, wb_sel_i} <= 2'b01;
      @(posedge clk_i);
      t_regs(); t_poll(); t_irq(); t_collide(); t_reset();
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
